// ==== hdl/bodt_bank.sv ====
// timer and down tally slot bank served one slot per clock by the engine
// assumes the engine holds exec inputs for one cycle and waits while busy
`timescale 1ns/10ps
`include "bodt_cfg.svh"
module bodt_bank #(
	parameter int TICK_CYCLES = `BODT_TICK_NS / `BODT_CLK_NS
) (
	input  wire logic                      clk,
	input  wire logic                      nrst,
	input  wire logic                      pwr_restore,
	input  wire logic                      exec_valid,
	input  wire logic [`BODT_IDX_W-1:0]    exec_slot,
	input  wire bodt_pkg::bodt_kind_t      exec_kind,
	input  wire logic                      exec_cond,
	input  wire logic                      exec_reset,
	input  wire logic                      exec_lockout_off,
	input  wire logic [`BODT_WORD_W-1:0]   preset_value,
	input  wire bodt_pkg::bodt_src_t       preset_src,
	input  wire logic                      preset_ind_bad,
	input  wire bodt_pkg::bodt_mode_t      ctrl_mode,
	input  wire logic                      fault_clear,
	input  wire logic [`BODT_IDX_W-1:0]    rd_slot,
	output logic                           rd_done_r,
	output logic [`BODT_WORD_W-1:0]        rd_count_r,
	output logic                           fault_flag_r,
	output logic                           busy_r,
	output logic                           tick_r
);
	function automatic logic is_bcd(input logic [`BODT_WORD_W-1:0] w);
		logic ok;
		ok = 1'b1;
		for (int d = 0; d < `BODT_DIGITS; d++) begin
			if (w[d*`BODT_DIGIT_W +: `BODT_DIGIT_W] > `BODT_DIGIT_MAX)
				ok = 1'b0;
		end
		return ok;
	endfunction

	// digit-wise decrement with borrow; caller keeps zero from wrapping
	function automatic logic [`BODT_WORD_W-1:0] bcd_dec(
		input logic [`BODT_WORD_W-1:0] w);
		logic [`BODT_WORD_W-1:0] r;
		logic                     brw;
		r = w;
		brw = 1'b1;
		for (int d = 0; d < `BODT_DIGITS; d++) begin
			if (brw) begin
				if (w[d*`BODT_DIGIT_W +: `BODT_DIGIT_W]
					== `BODT_DIGIT_ZERO) begin
					r[d*`BODT_DIGIT_W +: `BODT_DIGIT_W] = `BODT_DIGIT_MAX;
				end else begin
					r[d*`BODT_DIGIT_W +: `BODT_DIGIT_W] =
						w[d*`BODT_DIGIT_W +: `BODT_DIGIT_W]
						- `BODT_DIGIT_ONE;
					brw = 1'b0;
				end
			end
		end
		return r;
	endfunction

	logic [`BODT_WORD_W-1:0]  pv_mem   [`BODT_SLOTS];
	logic [`BODT_WORD_W-1:0]  sv_mem   [`BODT_SLOTS];
	logic                     done_mem [`BODT_SLOTS];
	logic                     cond_mem [`BODT_SLOTS];
	logic                     rst_mem  [`BODT_SLOTS];
	logic                     cnt_mem  [`BODT_SLOTS];
	logic [`BODT_SLOTS-1:0]   pend_r;
	logic [`BODT_TICK_W-1:0]  div_r;
	bodt_pkg::bodt_state_t    state_r;
	logic [`BODT_IDX_W-1:0]   sweep_r;
	logic                     sweep_all_r;

	wire tick_now = (div_r == `BODT_TICK_W'(TICK_CYCLES - 1));
	wire idle = (state_r == bodt_pkg::BODT_ST_IDLE);
	wire do_exec = exec_valid && idle;
	wire is_tally = (exec_kind == bodt_pkg::BODT_KIND_DOWN_TALLY);
	wire ext_ok = (ctrl_mode != bodt_pkg::BODT_MODE_PROGRAM);
	// an io-word preset is only taken outside program mode; otherwise the
	// stored preset stays, so a switch moved while editing cannot retime
	wire use_old = (preset_src == bodt_pkg::BODT_SRC_IO_WORD) && !ext_ok;
	wire [`BODT_WORD_W-1:0] sv_eff =
		use_old ? sv_mem[exec_slot] : preset_value;     // RULE_18 RULE_05
	wire sv_zero = (sv_eff == `BODT_ZERO_WORD);
	wire bad_sv = !is_bcd(sv_eff);
	wire bad_ind = (preset_src == bodt_pkg::BODT_SRC_DATA_STORE)
		&& preset_ind_bad;
	wire [`BODT_WORD_W-1:0] pv_old = pv_mem[exec_slot];
	wire pv_zero = (pv_old == `BODT_ZERO_WORD);
	wire [`BODT_WORD_W-1:0] pv_dec = bcd_dec(pv_old);
	wire dec_zero = (pv_dec == `BODT_ZERO_WORD);
	wire run_cond = exec_cond && !exec_lockout_off;          // RULE_14
	wire was_run = cond_mem[exec_slot];
	wire pend_now = pend_r[exec_slot];
	wire tal_edge = exec_cond && !was_run && !pv_zero;       // RULE_19
	wire rst_edge = exec_reset && !rst_mem[exec_slot];
	wire sweep_hit = sweep_all_r || !cnt_mem[sweep_r];       // RULE_15

	// tenth-second timebase as a one-cycle enable
	always_ff @(posedge clk) begin
		if (!nrst)
			div_r <= '0;
		else if (tick_now)
			div_r <= '0;
		else
			div_r <= div_r + `BODT_TICK_W'(1);
	end

	// a tick marks every slot at once; the slot consumes it when served
	// one pending bit per slot: a slot served less than once per tick
	// drops the extra ticks, so the engine's scan must beat the tick
	always_ff @(posedge clk) begin
		if (!nrst)
			pend_r <= '0;
		else if (tick_now)
			pend_r <= '1;                                      // RULE_20
		else if (do_exec)
			pend_r[exec_slot] <= 1'b0;
	end

	// full sweep after reset clears every slot; a restore sweep spares
	// tallies, which must keep their count through a power loss
	always_ff @(posedge clk) begin
		if (!nrst) begin
			state_r     <= bodt_pkg::BODT_ST_SWEEP;
			sweep_r     <= '0;
			sweep_all_r <= 1'b1;
		end else begin
			case (state_r)
			bodt_pkg::BODT_ST_SWEEP: begin
				sweep_r <= sweep_r + `BODT_IDX_W'(1);
				if (sweep_r == `BODT_LAST_IDX)
					state_r <= bodt_pkg::BODT_ST_IDLE;
			end
			default: begin
				if (pwr_restore) begin
					state_r     <= bodt_pkg::BODT_ST_SWEEP;
					sweep_r     <= '0;
					sweep_all_r <= 1'b0;
				end
			end
			endcase
		end
	end

	// slot storage; arrays carry no reset, the sweep initialises them
	always_ff @(posedge clk) begin
		if (!idle) begin
			if (sweep_hit) begin                               // RULE_21
				pv_mem[sweep_r]   <= sweep_all_r ? `BODT_ZERO_WORD
					: sv_mem[sweep_r];
				done_mem[sweep_r] <= 1'b0;
				cond_mem[sweep_r] <= 1'b0;
				rst_mem[sweep_r]  <= 1'b0;
			end
			if (sweep_all_r) begin
				sv_mem[sweep_r]  <= `BODT_ZERO_WORD;
				cnt_mem[sweep_r] <= 1'b0;
			end
		end else if (do_exec) begin                           // RULE_01
			sv_mem[exec_slot]  <= sv_eff;
			cnt_mem[exec_slot] <= is_tally;
			if (is_tally) begin
				// tallies keep their count across lockout and power loss
				if (!exec_lockout_off) begin
					cond_mem[exec_slot] <= exec_cond;
					rst_mem[exec_slot]  <= exec_reset;
					if (exec_reset) begin
						done_mem[exec_slot] <= 1'b0;
						if (rst_edge)
							pv_mem[exec_slot] <= sv_eff;           // RULE_19
					end else if (tal_edge) begin
						pv_mem[exec_slot]   <= pv_dec;
						done_mem[exec_slot] <= dec_zero;
					end
				end
			end else begin
				cond_mem[exec_slot] <= run_cond;
				if (!run_cond) begin
					pv_mem[exec_slot]   <= sv_eff;             // RULE_07
					done_mem[exec_slot] <= 1'b0;               // RULE_09
				end else if (!was_run) begin
					pv_mem[exec_slot]   <= sv_eff;             // RULE_06
					done_mem[exec_slot] <= sv_zero;            // RULE_10
				end else if (pend_now && !pv_zero) begin
					// first tick may land right after start
					pv_mem[exec_slot]   <= pv_dec;             // RULE_08 RULE_11
					done_mem[exec_slot] <= dec_zero;           // RULE_09
				end
			end
		end
	end

	// reads lag one cycle so the arrays can sit in plain block memory
	always_ff @(posedge clk) begin
		if (!nrst) begin
			rd_done_r  <= 1'b0;
			rd_count_r <= `BODT_ZERO_WORD;
		end else begin
			rd_done_r  <= done_mem[rd_slot];                   // RULE_03
			rd_count_r <= pv_mem[rd_slot];                     // RULE_04
		end
	end

	// a new fault outranks a clear in the same cycle, so none is lost
	always_ff @(posedge clk) begin
		if (!nrst)
			fault_flag_r <= 1'b0;
		else if (do_exec && (bad_sv || bad_ind))
			fault_flag_r <= 1'b1;                              // RULE_16 RULE_17
		else if (fault_clear)
			fault_flag_r <= 1'b0;
	end

	// busy also covers the cycle after a restore is taken, the first cycle of the sweep
	always_ff @(posedge clk) begin
		if (!nrst) begin
			busy_r <= 1'b1;
			tick_r <= 1'b0;
		end else begin
			busy_r <= !idle && !(sweep_r == `BODT_LAST_IDX)
				|| (idle && pwr_restore);
			tick_r <= tick_now;
		end
	end
endmodule

// ==== common/bodt_cfg.svh ====
// constants for the bcd on-delay timer bank
// assumes a 20 MHz clock and one slot operation per clock from the engine
// Behaviour
// RULE_01: slots 000 to 511 shared by timers and counters, selected by index.
// RULE_02: engine defines each slot index once; later reads are unlimited.
// RULE_03: each slot has a completion flag, off until preset elapses.
// RULE_04: each slot's remaining count is readable as a word.
// RULE_05: preset is immediate or a data word, always packed four-digit bcd.
// RULE_06: timer preset 0000 to 9999 bcd means 000.0 to 999.9 seconds.
// RULE_07: timer starts when condition goes on; condition off reloads preset.
// RULE_08: running timer counts down once per tenth-second tick.
// RULE_09: reaching zero sets completion flag until condition goes off.
// RULE_10: preset zero sets completion flag at once when condition is on.
// RULE_11: accuracy is zero to minus one tick; preset one may end at once.
// RULE_12: engine should use timer presets 0002 to 9999.
// RULE_13: engine should keep slots 000 to 015 for fast timers if needed.
// RULE_14: lockout section off resets timers inside it.
// RULE_15: power restore resets all timers and their flags.
// RULE_16: non-bcd preset sets fault flag; operation continues.
// RULE_17: bad indirect data store word also sets fault flag.
// RULE_18: preset from io word applies only in run or observe mode.
// RULE_19: down tally counts rising count edges; reset edge reloads, holds.
// RULE_20: one-cycle tenth-second tick reaches every timer slot together.
// RULE_21: reset clears flags and reloads presets; bcd decrement borrows.
`ifndef BODT_CFG_SVH
`define BODT_CFG_SVH
`define BODT_SLOTS      512
`define BODT_IDX_W      9
`define BODT_WORD_W     16
`define BODT_LAST_IDX   9'h1FF
`define BODT_ZERO_WORD  16'h0000
`define BODT_CLK_NS     50
`define BODT_TICK_NS    100000000
`define BODT_TICK_W     21
`define BODT_DIGITS     4
`define BODT_DIGIT_W    4
`define BODT_DIGIT_MAX  4'h9
`define BODT_DIGIT_ZERO 4'h0
`define BODT_DIGIT_ONE  4'h1
`endif

// ==== common/bodt_pkg.sv ====
// types for the bcd on-delay timer bank
// assumes bodt_cfg.svh supplies all numeric constants
package bodt_pkg;
	typedef enum logic {
		BODT_KIND_TIMER,
		BODT_KIND_DOWN_TALLY
	} bodt_kind_t;
	typedef enum logic [1:0] {
		BODT_SRC_IMMEDIATE,
		BODT_SRC_DATA_STORE,
		BODT_SRC_IO_WORD
	} bodt_src_t;
	typedef enum logic [1:0] {
		BODT_MODE_PROGRAM,
		BODT_MODE_OBSERVE,
		BODT_MODE_RUN
	} bodt_mode_t;
	typedef enum logic {
		BODT_ST_SWEEP,
		BODT_ST_IDLE
	} bodt_state_t;
endpackage

// ==== sim/bodt_bank_sva.sv ====
// port assertions for the timer bank
// assumes a sync active-low reset on clk
`timescale 1ns/10ps
module bodt_bank_sva #(
	parameter int TICK_CYCLES = 2000000
) (
	input wire logic                clk,
	input wire logic                nrst,
	input wire logic                pwr_restore,
	input wire logic                exec_valid,
	input wire bodt_pkg::bodt_src_t preset_src,
	input wire logic                preset_ind_bad,
	input wire logic                fault_clear,
	input wire logic                rd_done_r,
	input wire logic [15:0]         rd_count_r,
	input wire logic                fault_flag_r,
	input wire logic                busy_r,
	input wire logic                tick_r
);
	logic [31:0] gap_r;
	logic        seen_r;
	always_ff @(posedge clk) begin
		gap_r <= (!nrst || tick_r) ? 32'h0 : gap_r + 32'h1;
		seen_r <= nrst && (seen_r || tick_r);
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);
	sequence ind_req;
		exec_valid && !busy_r && preset_ind_bad && !$past(pwr_restore)
		&& preset_src == bodt_pkg::BODT_SRC_DATA_STORE;
	endsequence
	rst_clear_a: assert property (disable iff (1'b0) !nrst |=>
		busy_r && !rd_done_r && !fault_flag_r && rd_count_r == 16'h0000)
		else $error("outputs not cleared");
	tick_once_a: assert property (tick_r |=> !tick_r)
		else $error("tick too long");
	tick_gap_a: assert property (seen_r && tick_r |->
		gap_r == TICK_CYCLES - 1) else $error("tick early");
	tick_due_a: assert property (seen_r && gap_r == TICK_CYCLES - 1
		|-> tick_r) else $error("tick late");
	fault_hold_a: assert property (fault_flag_r && !fault_clear
		|=> fault_flag_r) else $error("fault lost");
	fault_clr_a: assert property (fault_flag_r && fault_clear
		&& !exec_valid |=> !fault_flag_r) else $error("fault kept");
	fault_ind_a: assert property (ind_req |=> fault_flag_r)
		else $error("indirect fault missed");
	done_zero_a: assert property (rd_done_r |->
		rd_count_r == 16'h0000) else $error("done with count left");
endmodule
bind bodt_bank bodt_bank_sva #(.TICK_CYCLES(TICK_CYCLES)) bodt_bank_sva_i (
	.clk(clk), .nrst(nrst), .pwr_restore(pwr_restore),
	.exec_valid(exec_valid), .preset_src(preset_src),
	.preset_ind_bad(preset_ind_bad), .fault_clear(fault_clear),
	.rd_done_r(rd_done_r), .rd_count_r(rd_count_r),
	.fault_flag_r(fault_flag_r), .busy_r(busy_r), .tick_r(tick_r));

// ==== sim/bodt_engine.sv ====
// ladder engine model driving the exec port
// assumes the bank takes a request on the edge that sees exec_valid
`timescale 1ns/10ps
module bodt_engine (
	input  wire logic            clk,
	output logic                 exec_valid,
	output logic [8:0]           exec_slot,
	output bodt_pkg::bodt_kind_t exec_kind,
	output logic                 exec_cond,
	output logic                 exec_reset,
	output logic                 exec_lockout_off,
	output logic [15:0]          preset_value,
	output bodt_pkg::bodt_src_t  preset_src,
	output logic                 preset_ind_bad
);
	initial begin
		{exec_valid, exec_cond, exec_reset, exec_lockout_off} = 4'h0;
		{exec_slot, preset_value, preset_ind_bad} = 26'h0;
		exec_kind = bodt_pkg::BODT_KIND_TIMER;
		preset_src = bodt_pkg::BODT_SRC_IMMEDIATE;
	end
	// callers define each slot once but also drive presets 0000 and non-bcd 00A0
	task automatic serve(input logic [8:0] s,
		input bodt_pkg::bodt_kind_t k, input logic c, r, l,
		input logic [15:0] p, input bodt_pkg::bodt_src_t sr, input logic b);
		@(posedge clk);
		exec_valid       <= 1'b1;
		exec_slot        <= s;
		exec_kind        <= k;
		exec_cond        <= c;
		exec_reset       <= r;
		exec_lockout_off <= l;
		preset_value     <= p;
		preset_src       <= sr;
		preset_ind_bad   <= b;
		@(posedge clk);
		exec_valid <= 1'b0;
		// a released preset word does not keep its old value
		preset_value <= ~p;
	endtask
endmodule

// ==== sim/bodt_bank_bench.sv ====
// self-checking bench for the timer bank
// assumes the engine model serves the exec port
`timescale 1ns/10ps
module bodt_bank_bench;
	localparam bodt_pkg::bodt_kind_t T = bodt_pkg::BODT_KIND_TIMER;
	localparam bodt_pkg::bodt_kind_t D = bodt_pkg::BODT_KIND_DOWN_TALLY;
	logic                 clk, nrst, pwr_restore, fault_clear, ev, ec, er;
	logic                 el, eb, done, flt, busy, tick;
	logic [8:0]           rs, es;
	logic [15:0]          cnt, ep;
	bodt_pkg::bodt_kind_t ek;
	bodt_pkg::bodt_src_t  esr;
	bodt_pkg::bodt_mode_t md;
	int                   fail_count, check_count;
	bodt_engine bodt_engine_i (.clk(clk), .exec_valid(ev), .exec_slot(es),
		.exec_kind(ek), .exec_cond(ec), .exec_reset(er),
		.exec_lockout_off(el), .preset_value(ep), .preset_src(esr),
		.preset_ind_bad(eb));
	bodt_bank #(.TICK_CYCLES(20)) bodt_bank_i (.clk(clk), .nrst(nrst),
		.pwr_restore(pwr_restore), .exec_valid(ev), .exec_slot(es),
		.exec_kind(ek), .exec_cond(ec), .exec_reset(er),
		.exec_lockout_off(el), .preset_value(ep), .preset_src(esr),
		.preset_ind_bad(eb), .ctrl_mode(md),
		.fault_clear(fault_clear), .rd_slot(rs), .rd_done_r(done),
		.rd_count_r(cnt), .fault_flag_r(flt), .busy_r(busy), .tick_r(tick));
	task automatic cmp(input logic [15:0] g, e);
		check_count++;
		if (g !== e) begin
			fail_count++;
			$display("ERROR %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic cmp_flag(input logic g, e);
		check_count++;
		if (g !== e) begin
			fail_count++;
			$display("ERROR %0t got %h exp %h", $time, g, e);
		end
	endtask
	// sample one step after the edge so the registered read has settled
	task automatic rd(input logic [8:0] s, input logic [15:0] c,
		input logic d);
		@(posedge clk);
		rs <= s;
		repeat (2) @(posedge clk);
		#1;
		cmp(cnt, c);
		cmp_flag(done, d);
	endtask
	task automatic sv(input logic [8:0] s, input bodt_pkg::bodt_kind_t k,
		input logic c, r, l, input logic [15:0] p);
		bodt_engine_i.serve(s, k, c, r, l, p,
			bodt_pkg::BODT_SRC_IMMEDIATE, 1'b0);
	endtask
	// at least one tick lands between two serves
	task automatic tk;
		repeat (21) @(posedge clk);
	endtask
	task automatic wb;
		int i;
		repeat (3) @(posedge clk);
		for (i = 0; i < 600 && busy !== 1'b0; i++) @(posedge clk);
		// a sweep that never ends is a failure, not a reason to go on
		if (busy !== 1'b0) begin
			fail_count++;
			test_done;
		end
		@(posedge clk);
	endtask
	task automatic test_done;
		$display("checks %0d errors %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	initial begin
		repeat (9000) @(posedge clk);
		fail_count++;
		test_done;
	end
	initial begin
		{nrst, pwr_restore, fault_clear, rs} = 12'h0;
		md = bodt_pkg::BODT_MODE_RUN;
		repeat (10) @(posedge clk);
		nrst <= 1'b1;
		wb;
		rd(9'h1FF, 16'h0000, 1'b0);
		sv(9'h1FF, T, 1, 0, 0, 16'h0002);
		rd(9'h1FF, 16'h0002, 1'b0);
		tk;
		sv(9'h1FF, T, 1, 0, 0, 16'h0002);
		rd(9'h1FF, 16'h0001, 1'b0);
		tk;
		sv(9'h1FF, T, 1, 0, 0, 16'h0002);
		tk;
		sv(9'h1FF, T, 1, 0, 0, 16'h0002);
		rd(9'h1FF, 16'h0000, 1'b1);
		sv(9'h1FF, T, 0, 0, 0, 16'h0002);
		rd(9'h1FF, 16'h0002, 1'b0);
		sv(9'h010, T, 1, 0, 0, 16'h0000);
		rd(9'h010, 16'h0000, 1'b1);
		sv(9'h004, T, 1, 0, 0, 16'h0100);
		tk;
		sv(9'h004, T, 1, 0, 0, 16'h0100);
		rd(9'h004, 16'h0099, 1'b0);
		sv(9'h004, T, 1, 0, 1, 16'h0100);
		rd(9'h004, 16'h0100, 1'b0);
		sv(9'h003, T, 1, 0, 0, 16'h00A0);
		#1;
		cmp_flag(flt, 1'b1);
		@(posedge clk);
		fault_clear <= 1'b1;
		@(posedge clk);
		fault_clear <= 1'b0;
		#1;
		cmp_flag(flt, 1'b0);
		bodt_engine_i.serve(9'h005, T, 1, 0, 0, 16'h0005,
			bodt_pkg::BODT_SRC_DATA_STORE, 1'b1);
		#1;
		cmp_flag(flt, 1'b1);
		sv(9'h002, D, 0, 1, 0, 16'h0002);
		sv(9'h002, D, 1, 0, 0, 16'h0002);
		sv(9'h002, D, 1, 0, 0, 16'h0002);
		rd(9'h002, 16'h0001, 1'b0);
		sv(9'h002, D, 0, 0, 0, 16'h0002);
		sv(9'h002, D, 1, 0, 0, 16'h0002);
		rd(9'h002, 16'h0000, 1'b1);
		sv(9'h020, T, 1, 0, 0, 16'h0003);
		md <= bodt_pkg::BODT_MODE_PROGRAM;
		bodt_engine_i.serve(9'h020, T, 0, 0, 0, 16'h0007,
			bodt_pkg::BODT_SRC_IO_WORD, 1'b0);
		md <= bodt_pkg::BODT_MODE_OBSERVE;
		rd(9'h020, 16'h0003, 1'b0);
		bodt_engine_i.serve(9'h020, T, 0, 0, 0, 16'h0007,
			bodt_pkg::BODT_SRC_IO_WORD, 1'b0);
		md <= bodt_pkg::BODT_MODE_RUN;
		rd(9'h020, 16'h0007, 1'b0);
		sv(9'h1FF, T, 1, 0, 0, 16'h0002);
		tk;
		sv(9'h1FF, T, 1, 0, 0, 16'h0002);
		pwr_restore <= 1'b1;
		@(posedge clk);
		pwr_restore <= 1'b0;
		#1;
		cmp_flag(busy, 1'b1);
		wb;
		rd(9'h1FF, 16'h0002, 1'b0);
		rd(9'h002, 16'h0000, 1'b1);
		rd(9'h020, 16'h0007, 1'b0);
		test_done;
	end
endmodule
